/* src/axil_write_capture.sv */
// AXI4-Lite write address/data capture and write response
`timescale 1ns/1ps
module axil_write_capture
  import keyed_reset_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready_q,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic [STRB_W-1:0] wstrb,
  input wire logic wvalid,
  output logic wready_q,
  output logic bvalid_q,
  output logic [1:0] bresp_q,
  input wire logic bready,
  input wire logic wr_err,
  output logic wr_fire,
  output logic [ADDR_W-1:0] wr_addr_q,
  output logic [DATA_W-1:0] wr_data_q,
  output logic [STRB_W-1:0] wr_strb_q
);
  logic aw_full_q;
  logic w_full_q;
  logic aw_full_d;
  logic w_full_d;

  // One write at a time: fire only with both halves and no response pending
  assign wr_fire = aw_full_q && w_full_q && !bvalid_q;

  // Holding flags; channels taken in either order
  always_comb begin
    aw_full_d = aw_full_q;
    w_full_d = w_full_q;
    if (wr_fire) begin
      aw_full_d = 1'b0;
      w_full_d = 1'b0;
    end
    if (awvalid && awready_q) aw_full_d = 1'b1;
    if (wvalid && wready_q) w_full_d = 1'b1;
  end

  // Ready comes from a flop, so it lags a cycle after reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
    end else begin
      aw_full_q <= aw_full_d;
      w_full_q <= w_full_d;
      awready_q <= !aw_full_d;
      wready_q <= !w_full_d;
    end
  end

  // Payload holding
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_addr_q <= '0;
      wr_data_q <= '0;
      wr_strb_q <= '0;
    end else begin
      if (awvalid && awready_q) wr_addr_q <= awaddr;
      if (wvalid && wready_q) begin
        wr_data_q <= wdata;
        wr_strb_q <= wstrb;
      end
    end
  end

  // Write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      bresp_q <= wr_err ? RESP_SLVERR : RESP_OKAY;
    end else if (bready) begin
      bvalid_q <= 1'b0;
    end
  end
endmodule : axil_write_capture

/* src/key_gate.sv */
// Lock state of the software reset control key gate
`timescale 1ns/1ps
module key_gate
  import keyed_reset_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic wr_fire,
  input wire logic wr_is_key,
  input wire logic wr_is_prot,
  input wire logic key_match,
  output logic unlocked_q,
  output logic accept,
  output logic reject
);
  gate_state_t state_q;

  // Protected write passes only while unlocked
  assign accept = wr_fire && wr_is_prot && (state_q == GATE_UNLOCKED);
  assign reject = wr_fire && wr_is_prot && (state_q != GATE_UNLOCKED);

  // Gate state; reset is the locked, zero-key state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= GATE_LOCKED;
    end else if (wr_fire) begin
      case (state_q)
        GATE_LOCKED: begin
          if (wr_is_key && key_match) state_q <= GATE_UNLOCKED;
        end
        GATE_UNLOCKED: begin
          if (!(wr_is_key && key_match)) state_q <= GATE_LOCKED;
        end
        default: begin
          state_q <= GATE_LOCKED;
        end
      endcase
    end
  end

  // Flop copy for the status bit and the output pin
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      unlocked_q <= 1'b0;
    end else if (wr_fire) begin
      unlocked_q <= wr_is_key && key_match && (state_q == GATE_LOCKED || state_q == GATE_UNLOCKED);
    end
  end
endmodule : key_gate

/* src/keyed_reset_control_gate.sv */
// Keyed reset control gate and oscillator trim register behind AXI4-Lite
//
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/1ps
module keyed_reset_control_gate
  import keyed_reset_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic [STRB_W-1:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [DATA_W-1:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic [REG_W-1:0] sw_reset_ctrl,
  output logic [TRIM_W-1:0] osc_trim,
  output logic key_unlocked
);
  logic wr_fire;
  logic [ADDR_W-1:0] wr_addr_q;
  logic [DATA_W-1:0] wr_data_q;
  logic [STRB_W-1:0] wr_strb_q;
  logic wr_is_key;
  logic wr_is_prot;
  logic wr_is_trim;
  logic wr_is_stat;
  logic wr_err;
  logic key_match;
  logic unlocked_q;
  logic accept;
  logic reject;
  logic [REG_W-1:0] sw_reset_ctrl_q;
  logic [REG_W-1:0] trim_q;
  logic [TRIM_W-1:0] osc_trim_q;
  logic reject_q;
  logic arready_q;
  logic rvalid_q;
  logic [DATA_W-1:0] rdata_q;
  logic [1:0] rresp_q;
  logic ar_take;
  logic [DATA_W-1:0] rd_word;
  logic rd_err;

  // Write channel capture and response
  axil_write_capture u_wr (
    .aclk(aclk),
    .aresetn(aresetn),
    .awaddr(awaddr),
    .awvalid(awvalid),
    .awready_q(awready),
    .wdata(wdata),
    .wstrb(wstrb),
    .wvalid(wvalid),
    .wready_q(wready),
    .bvalid_q(bvalid),
    .bresp_q(bresp),
    .bready(bready),
    .wr_err(wr_err),
    .wr_fire(wr_fire),
    .wr_addr_q(wr_addr_q),
    .wr_data_q(wr_data_q),
    .wr_strb_q(wr_strb_q)
  );

  // Write decode
  assign wr_is_key = hit(wr_addr_q, OFF_KEY);
  assign wr_is_prot = hit(wr_addr_q, OFF_SW_RESET_CTRL);
  assign wr_is_trim = hit(wr_addr_q, OFF_TRIM);
  assign wr_is_stat = hit(wr_addr_q, OFF_STATUS);
  assign wr_err = !(wr_is_key || wr_is_prot || wr_is_trim || wr_is_stat);
  assign key_match = (wr_data_q[REG_W-1:0] == UNLOCK_KEY) && (wr_strb_q[1:0] == 2'b11);

  // Host ordering is its own duty; gate just tracks writes
  key_gate u_gate (
    .aclk(aclk),
    .aresetn(aresetn),
    .wr_fire(wr_fire),
    .wr_is_key(wr_is_key),
    .wr_is_prot(wr_is_prot),
    .key_match(key_match),
    .unlocked_q(unlocked_q),
    .accept(accept),
    .reject(reject)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sw_reset_ctrl_q <= SW_RESET_CTRL_RESET;
    end else if (accept) begin
      sw_reset_ctrl_q <= merge(sw_reset_ctrl_q, wr_data_q, wr_strb_q);
    end
  end

  // trim register, all 16 bits kept
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trim_q <= TRIM_RESET;
    end else if (wr_fire && wr_is_trim) begin
      trim_q <= merge(trim_q, wr_data_q, wr_strb_q);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      osc_trim_q <= TRIM_FIELD_RESET;
    end else if (wr_fire && wr_is_trim && wr_strb_q[0]) begin
      osc_trim_q <= wr_data_q[TRIM_LSB +: TRIM_W];
    end
  end

  // Sticky reject flag; a new reject beats a clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      reject_q <= 1'b0;
    end else if (reject) begin
      reject_q <= 1'b1;
    end else if (wr_fire && wr_is_stat && wr_strb_q[0] && wr_data_q[STAT_REJECT_BIT]) begin
      reject_q <= 1'b0;
    end
  end

  // Read mux
  always_comb begin
    rd_word = '0;
    rd_err = 1'b0;
    if (hit(araddr, OFF_KEY)) begin
      rd_word = '0;
    end else if (hit(araddr, OFF_SW_RESET_CTRL)) begin
      rd_word[REG_W-1:0] = sw_reset_ctrl_q;
    end else if (hit(araddr, OFF_STATUS)) begin
      rd_word[STAT_UNLOCKED_BIT] = unlocked_q;
      rd_word[STAT_REJECT_BIT] = reject_q;
    end else if (hit(araddr, OFF_TRIM)) begin
      rd_word[REG_W-1:0] = trim_q;
    end else begin
      rd_err = 1'b1;
    end
  end

  assign ar_take = arvalid && arready_q;

  // Read channel; one read under way, data one cycle after address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= RESP_OKAY;
    end else if (ar_take) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rdata_q <= rd_word;
      rresp_q <= rd_err ? RESP_SLVERR : RESP_OKAY;
    end else if (rvalid_q && rready) begin
      rvalid_q <= 1'b0;
      arready_q <= 1'b1;
    end else if (!rvalid_q) begin
      arready_q <= 1'b1;
    end
  end

  // Outputs straight from flops
  assign arready = arready_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;
  assign sw_reset_ctrl = sw_reset_ctrl_q;
  assign osc_trim = osc_trim_q;
  assign key_unlocked = unlocked_q;

  // Checks on the gate and the registers
  property p_key_unlocks;
    @(posedge aclk) disable iff (!aresetn)
      wr_fire && wr_is_key && key_match |=> unlocked_q;
  endproperty
  a_key_unlocks: assert property (p_key_unlocks) else $error("key did not unlock");

  property p_bad_key_locks;
    @(posedge aclk) disable iff (!aresetn)
      wr_fire && wr_is_key && !key_match |=> !unlocked_q ##1 !unlocked_q || wr_fire;
  endproperty
  a_bad_key_locks: assert property (p_bad_key_locks) else $error("wrong key left gate open");

  property p_other_relocks;
    @(posedge aclk) disable iff (!aresetn)
      wr_fire && unlocked_q && !wr_is_key && !wr_is_prot |=> !unlocked_q;
  endproperty
  a_other_relocks: assert property (p_other_relocks) else $error("other write kept gate open");

  property p_key_reads_zero;
    @(posedge aclk) disable iff (!aresetn)
      ar_take && hit(araddr, OFF_KEY) |=> rvalid_q && rdata_q == 32'h0000_0000 && rresp_q == RESP_OKAY;
  endproperty
  a_key_reads_zero: assert property (p_key_reads_zero) else $error("key register read nonzero");

  property p_trim_field;
    @(posedge aclk) disable iff (!aresetn)
      ##1 osc_trim_q == trim_q[TRIM_LSB +: TRIM_W];
  endproperty
  a_trim_field: assert property (p_trim_field) else $error("trim output differs from field");

  property p_trim_reset;
    @(posedge aclk) disable iff (!aresetn)
      $rose(aresetn) |-> trim_q == 16'h0088 && osc_trim_q == 4'h8;
  endproperty
  a_trim_reset: assert property (p_trim_reset) else $error("trim reset value wrong");

  property p_locked_ignored;
    @(posedge aclk) disable iff (!aresetn)
      wr_fire && wr_is_prot && !unlocked_q |=> $stable(sw_reset_ctrl_q) && reject_q;
  endproperty
  a_locked_ignored: assert property (p_locked_ignored) else $error("locked write changed register");

  property p_relock_after;
    @(posedge aclk) disable iff (!aresetn)
      wr_fire && wr_is_prot && unlocked_q |=> !unlocked_q;
  endproperty
  a_relock_after: assert property (p_relock_after) else $error("gate open after protected write");

  // Register contents move only on their own accepted writes
  property p_ctrl_hold;
    @(posedge aclk) disable iff (!aresetn)
      !accept |=> $stable(sw_reset_ctrl_q);
  endproperty
  a_ctrl_hold: assert property (p_ctrl_hold) else $error("protected register changed without accept");

  property p_locked_stays;
    @(posedge aclk) disable iff (!aresetn)
      wr_fire && wr_is_prot && !unlocked_q |=> !unlocked_q;
  endproperty
  a_locked_stays: assert property (p_locked_stays) else $error("locked protected write opened gate");

  property p_no_unlock_without_key;
    @(posedge aclk) disable iff (!aresetn)
      !unlocked_q && !(wr_fire && wr_is_key && key_match) |=> !unlocked_q;
  endproperty
  a_no_unlock_without_key: assert property (p_no_unlock_without_key) else $error("gate opened without key");

  property p_unmapped_relocks;
    @(posedge aclk) disable iff (!aresetn)
      wr_fire && wr_err |=> !unlocked_q && bvalid && bresp == RESP_SLVERR;
  endproperty
  a_unmapped_relocks: assert property (p_unmapped_relocks) else $error("unmapped write not refused");

  property p_key_write_ok;
    @(posedge aclk) disable iff (!aresetn)
      wr_fire && wr_is_key |=> bvalid && bresp == RESP_OKAY;
  endproperty
  a_key_write_ok: assert property (p_key_write_ok) else $error("key write refused");

  property p_trim_hold;
    @(posedge aclk) disable iff (!aresetn)
      !(wr_fire && wr_is_trim) |=> $stable(trim_q);
  endproperty
  a_trim_hold: assert property (p_trim_hold) else $error("trim register changed without write");

  property p_osc_hold;
    @(posedge aclk) disable iff (!aresetn)
      !(wr_fire && wr_is_trim && wr_strb_q[0]) |=> $stable(osc_trim_q);
  endproperty
  a_osc_hold: assert property (p_osc_hold) else $error("oscillator trim changed without write");

  property p_trim_read;
    @(posedge aclk) disable iff (!aresetn)
      ar_take && hit(araddr, OFF_TRIM) |=> rdata_q == {16'h0000, $past(trim_q)} && rresp_q == RESP_OKAY;
  endproperty
  a_trim_read: assert property (p_trim_read) else $error("trim read data wrong");

  // Sticky flag drops only on its own clear
  property p_reject_sticky;
    @(posedge aclk) disable iff (!aresetn)
      reject_q && !(wr_fire && wr_is_stat && wr_strb_q[0] && wr_data_q[STAT_REJECT_BIT]) |=> reject_q;
  endproperty
  a_reject_sticky: assert property (p_reject_sticky) else $error("reject flag lost");

  property p_status_read;
    @(posedge aclk) disable iff (!aresetn)
      ar_take && hit(araddr, OFF_STATUS) |=> rdata_q == {30'h0, $past(reject_q), $past(unlocked_q)};
  endproperty
  a_status_read: assert property (p_status_read) else $error("status read data wrong");

  c_unlock_write: cover property (@(posedge aclk) disable iff (!aresetn) accept);
  c_reject_write: cover property (@(posedge aclk) disable iff (!aresetn) reject);
  c_trim_write: cover property (@(posedge aclk) disable iff (!aresetn) wr_fire && wr_is_trim);
  c_bad_read: cover property (@(posedge aclk) disable iff (!aresetn) ar_take && rd_err);
  c_status_clear: cover property (@(posedge aclk) disable iff (!aresetn) reject_q ##1 !reject_q);
endmodule : keyed_reset_control_gate

/* src/keyed_reset_pkg.sv */
// Shared constants, types and helpers for the keyed reset control gate
package keyed_reset_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int REG_W = 16;
  localparam int STRB_W = DATA_W / 8;

  // Byte addresses of the registers
  localparam logic [ADDR_W-1:0] OFF_KEY = 12'hA5C;
  localparam logic [ADDR_W-1:0] OFF_SW_RESET_CTRL = 12'hA60;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 12'hA64;
  localparam logic [ADDR_W-1:0] OFF_TRIM = 12'hA6C;

  // Key and reset values
  localparam logic [REG_W-1:0] UNLOCK_KEY = 16'h12EA;
  localparam logic [REG_W-1:0] KEY_RESET = 16'h0000;
  localparam logic [REG_W-1:0] TRIM_RESET = 16'h0088;
  localparam logic [REG_W-1:0] SW_RESET_CTRL_RESET = 16'h0000;

  // Trim field of the oscillator trim register
  localparam int TRIM_LSB = 0;
  localparam int TRIM_W = 4;
  localparam logic [TRIM_W-1:0] TRIM_FIELD_RESET = 4'h8;

  // Status register bits
  localparam int STAT_UNLOCKED_BIT = 0;
  localparam int STAT_REJECT_BIT = 1;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    GATE_LOCKED = 2'b01,
    GATE_UNLOCKED = 2'b10
  } gate_state_t;

  // Word match, low address bits ignored
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
    hit = (a[ADDR_W-1:2] == off[ADDR_W-1:2]);
  endfunction : hit

  // Byte-lane merge into a 16-bit register
  function automatic logic [REG_W-1:0] merge(input logic [REG_W-1:0] old, input logic [DATA_W-1:0] d,
                                             input logic [STRB_W-1:0] s);
    merge = old;
    if (s[0]) merge[7:0] = d[7:0];
    if (s[1]) merge[15:8] = d[15:8];
  endfunction : merge
endpackage : keyed_reset_pkg

/* tb/tb_top.sv */
// Self-checking bench for the keyed reset control gate over AXI4-Lite
`timescale 1ns/1ps
`define CHECK(nm, e, g) begin tests_run++; if ((e) !== (g)) begin err_total++; \
  $display("FAIL %s expected %0h seen %0h", nm, e, g); end end
module tb_top
  import keyed_reset_pkg::*;
;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [ADDR_W-1:0] awaddr = '0;
  logic awvalid = 1'b0;
  logic awready;
  logic [DATA_W-1:0] wdata = '0;
  logic [STRB_W-1:0] wstrb = '0;
  logic wvalid = 1'b0;
  logic wready;
  logic [1:0] bresp;
  logic bvalid;
  logic bready = 1'b0;
  logic [ADDR_W-1:0] araddr = '0;
  logic arvalid = 1'b0;
  logic arready;
  logic [DATA_W-1:0] rdata;
  logic [1:0] rresp;
  logic rvalid;
  logic rready = 1'b0;
  logic [REG_W-1:0] sw_reset_ctrl;
  logic [TRIM_W-1:0] osc_trim;
  logic key_unlocked;
  int err_total = 0;
  int tests_run = 0;
  int cycles = 0;

  keyed_reset_control_gate uut (
    .aclk(aclk),
    .aresetn(aresetn),
    .awaddr(awaddr),
    .awvalid(awvalid),
    .awready(awready),
    .wdata(wdata),
    .wstrb(wstrb),
    .wvalid(wvalid),
    .wready(wready),
    .bresp(bresp),
    .bvalid(bvalid),
    .bready(bready),
    .araddr(araddr),
    .arvalid(arvalid),
    .arready(arready),
    .rdata(rdata),
    .rresp(rresp),
    .rvalid(rvalid),
    .rready(rready),
    .sw_reset_ctrl(sw_reset_ctrl),
    .osc_trim(osc_trim),
    .key_unlocked(key_unlocked)
  );

  // 125 MHz clock
  always #4 aclk = ~aclk;

  task summarize;
    $display("Comparisons %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : summarize

  // Hang guard, far above the few hundred cycles the sequence needs
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      err_total++;
      summarize();
    end
  end

  // Write: AW and W offered together, each released once taken; outputs looked at mid-cycle
  task automatic axi_write(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                           input logic [STRB_W-1:0] s, input logic [1:0] er);
    logic take_aw;
    logic take_w;
    logic take_b;
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= s;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge aclk);
      take_aw = awvalid && awready;
      take_w = wvalid && wready;
      take_b = bvalid && bready;
      if (take_b) `CHECK("bresp", er, bresp)
      @(posedge aclk);
      if (take_aw) awvalid <= 1'b0;
      if (take_w) wvalid <= 1'b0;
    end while (!take_b);
    bready <= 1'b0;
  endtask : axi_write

  // Read: rready held until rvalid is seen, data taken at that edge
  task automatic axi_read(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] ed, input logic [1:0] er);
    logic take_ar;
    logic take_r;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge aclk);
      take_ar = arvalid && arready;
      take_r = rvalid && rready;
      if (take_r) begin
        `CHECK("rdata", ed, rdata)
        `CHECK("rresp", er, rresp)
      end
      @(posedge aclk);
      if (take_ar) arvalid <= 1'b0;
    end while (!take_r);
    rready <= 1'b0;
  endtask : axi_read

  // Main sequence
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    // Reset state of gate and trim
    `CHECK("osc_trim", 4'h8, osc_trim)
    `CHECK("key_unlocked", 1'b0, key_unlocked)
    axi_read(OFF_TRIM, 32'h00000088, RESP_OKAY);
    axi_read(OFF_KEY, 32'h00000000, RESP_OKAY);
    // Locked gate drops protected writes
    axi_write(OFF_SW_RESET_CTRL, 32'h0000BEEF, 4'h3, RESP_OKAY);
    `CHECK("sw_reset_ctrl", 16'h0000, sw_reset_ctrl)
    axi_read(OFF_STATUS, 32'h00000002, RESP_OKAY);
    // Half-written or wrong key must not unlock
    axi_write(OFF_KEY, 32'h000012EA, 4'h1, RESP_OKAY);
    `CHECK("key_unlocked", 1'b0, key_unlocked)
    axi_write(OFF_KEY, 32'h000012EB, 4'h3, RESP_OKAY);
    `CHECK("key_unlocked", 1'b0, key_unlocked)
    // Correct key, a read in between keeps the gate open
    axi_write(OFF_KEY, 32'h000012EA, 4'h3, RESP_OKAY);
    `CHECK("key_unlocked", 1'b1, key_unlocked)
    axi_read(OFF_KEY, 32'h00000000, RESP_OKAY);
    axi_read(OFF_STATUS, 32'h00000003, RESP_OKAY);
    `CHECK("key_unlocked", 1'b1, key_unlocked)
    axi_write(OFF_SW_RESET_CTRL, 32'h00001234, 4'h3, RESP_OKAY);
    `CHECK("sw_reset_ctrl", 16'h1234, sw_reset_ctrl)
    `CHECK("key_unlocked", 1'b0, key_unlocked)
    // Second protected write without a new key is dropped
    axi_write(OFF_SW_RESET_CTRL, 32'h00005555, 4'h3, RESP_OKAY);
    `CHECK("sw_reset_ctrl", 16'h1234, sw_reset_ctrl)
    // Intervening trim write relocks
    axi_write(OFF_KEY, 32'h000012EA, 4'h3, RESP_OKAY);
    axi_write(OFF_TRIM, 32'h00000005, 4'h3, RESP_OKAY);
    `CHECK("key_unlocked", 1'b0, key_unlocked)
    `CHECK("osc_trim", 4'h5, osc_trim)
    axi_write(OFF_SW_RESET_CTRL, 32'h00006666, 4'h3, RESP_OKAY);
    `CHECK("sw_reset_ctrl", 16'h1234, sw_reset_ctrl)
    // Unmapped write is refused yet still relocks
    axi_write(OFF_KEY, 32'h000012EA, 4'h3, RESP_OKAY);
    axi_write(12'h100, 32'h00000000, 4'h3, RESP_SLVERR);
    `CHECK("key_unlocked", 1'b0, key_unlocked)
    // Key written twice still opens for one protected write
    axi_write(OFF_KEY, 32'h000012EA, 4'h3, RESP_OKAY);
    axi_write(OFF_KEY, 32'h000012EA, 4'h3, RESP_OKAY);
    axi_write(OFF_SW_RESET_CTRL, 32'h0000A5A5, 4'h3, RESP_OKAY);
    `CHECK("sw_reset_ctrl", 16'hA5A5, sw_reset_ctrl)
    // Clearing the sticky flag is a write too, so it relocks
    axi_write(OFF_KEY, 32'h000012EA, 4'h3, RESP_OKAY);
    axi_write(OFF_STATUS, 32'h00000002, 4'h1, RESP_OKAY);
    `CHECK("key_unlocked", 1'b0, key_unlocked)
    axi_read(OFF_STATUS, 32'h00000000, RESP_OKAY);
    // Every trim code, upper bits kept as written
    for (int i = 0; i < 16; i++) begin
      axi_write(OFF_TRIM, 32'h00000AB0 | i, 4'h3, RESP_OKAY);
      `CHECK("osc_trim", i[3:0], osc_trim)
      axi_read(OFF_TRIM, 32'h00000AB0 | i, RESP_OKAY);
    end
    // Upper lane only leaves the trim field alone
    axi_write(OFF_TRIM, 32'h00001207, 4'h2, RESP_OKAY);
    `CHECK("osc_trim", 4'hF, osc_trim)
    axi_read(OFF_TRIM, 32'h000012BF, RESP_OKAY);
    axi_read(12'h100, 32'h00000000, RESP_SLVERR);
    // Reset in mid-run restores every register
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    `CHECK("osc_trim", 4'h8, osc_trim)
    `CHECK("sw_reset_ctrl", 16'h0000, sw_reset_ctrl)
    `CHECK("key_unlocked", 1'b0, key_unlocked)
    axi_read(OFF_TRIM, 32'h00000088, RESP_OKAY);
    axi_read(OFF_STATUS, 32'h00000000, RESP_OKAY);
    summarize();
  end
endmodule : tb_top
